// *** sfc_client_model.sv ***
// Behavioural model of the upstream clients and walk logic around the context block.
// Assumes the bench calls its tasks from one process; every change lands right after a rising edge.
`timescale 1ns/100ps

module sfc_client_model
  import sfc_pkg::*;
(
  // Clock
  input wire logic clock,
  // Walk and client side
  output logic transEnable,
  output sfc_pkg::sfc_fault_s faultIn,
  output sfc_pkg::sfc_attr_s attrIn,
  output sfc_pkg::sfc_attr_s prevAttr,
  output logic barrierValid,
  output logic [1:0] barrierDomain,
  output logic s1WalkAccess,
  output logic s2DeviceMem,
  output sfc_pkg::sfc_maint_s maintIn
);
  // Quiet levels at time zero so nothing reaches the block before reset ends
  initial begin
    transEnable = 1'b1;
    faultIn = '0;
    attrIn = '0;
    prevAttr = '0;
    barrierValid = 1'b0;
    barrierDomain = 2'h0;
    s1WalkAccess = 1'b0;
    s2DeviceMem = 1'b0;
    maintIn = '0;
  end

  // One-cycle fault report with inAddr inverted; ipa is scrambled after the pulse so stale data cannot pass
  task automatic send_fault(input sfc_fkind_e kind, input logic nst, input logic walk, input logic [63:0] adr);
    @(posedge clock);
    faultIn <= '{valid: 1'b1, kind: kind, combined_translation_flag: nst, s1WalkFault: walk, inAddr: ~adr, ipa: adr};
    @(posedge clock);
    faultIn <= '{valid: 1'b0, kind: SFC_FK_OTHER, combined_translation_flag: 1'b0, s1WalkFault: 1'b0, inAddr: adr, ipa: ~adr};
  endtask : send_fault

  // Translation enable and own allocation hints
  task automatic set_attr(input logic te, input logic [1:0] w, input logic [1:0] r);
    @(posedge clock);
    transEnable <= te;
    attrIn.wAlloc <= w;
    attrIn.rAlloc <= r;
  endtask : set_attr

  // Own and previous-step shareability and memory attribute codes
  task automatic set_share(input logic [1:0] own, input logic [1:0] prev, input logic [3:0] ma, input logic [3:0] pma);
    @(posedge clock);
    attrIn.share <= own;
    attrIn.memory_attribute_field <= ma;
    prevAttr.share <= prev;
    prevAttr.memory_attribute_field <= pma;
  endtask : set_share

  // One client barrier; the domain line is inverted afterwards, not left holding
  task automatic pulse_barrier(input logic [1:0] dom);
    @(posedge clock);
    barrierValid <= 1'b1;
    barrierDomain <= dom;
    @(posedge clock);
    barrierValid <= 1'b0;
    barrierDomain <= ~dom;
  endtask : pulse_barrier

  // Stage 1 walk access and stage 2 memory type levels
  task automatic set_walk(input logic acc, input logic dev);
    @(posedge clock);
    s1WalkAccess <= acc;
    s2DeviceMem <= dev;
  endtask : set_walk

  // One TLB maintenance request
  task automatic pulse_maint();
    @(posedge clock);
    maintIn <= '{valid: 1'b1, tlbOp: 1'b1, bpInvAll: 1'b0, icInvAll: 1'b0};
    @(posedge clock);
    maintIn <= '0;
  endtask : pulse_maint
endmodule : sfc_client_model

// *** sfc_context_ctrl.sv ***
// Stage 2 context bank: fault address capture, control register, attribute overrides.
// Assumes fault reports, attributes and walk checks come from logic on the same clock.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/100ps

// Summary of operation
// (RULE_01) Combined_translation_flag translation faulting at stage 2 captures the intermediate address.
// (RULE_02) Without combined_translation_flag support the register mirrors fault address; writes ignored.
// (RULE_03) Capture only on translation, access, external, address size faults.
// (RULE_04) Also capture on permission fault with combined_translation_flag and walk fault flags set.
// (RULE_05) Low bound is 12, 14 or 16 by granule support.
// (RULE_06) Address bits M-1..N held; bits 63..M read zero.
// (RULE_07) Storage covers larger of upstream and intermediate address size.
// (RULE_08) Write allocate field sets write hint when translation disabled.
// (RULE_09) Read allocate field sets read hint when translation disabled.
// (RULE_10) Shareability field sets shareability when translation disabled; code merges it with the previous step, stricter wins.
// (RULE_11) Stage 2 shareability merges with previous step, not replaces.
// (RULE_12) Force broadcast bit broadcasts TLB, predictor and icache maintenance.
// (RULE_13) Memory attribute field overrides when disabled, combined at stage 2.
// (RULE_14) Barrier upgrade sets minimum barrier shareability domain.
// (RULE_15) Protected walk faults stage 1 walks to Device memory.
// (RULE_16) Bits 20, 12, 11..9 reserved and read zero.
module sfc_context_ctrl #(
  parameter int ADDR_BITS = 48,
  parameter bit HAS_COMBINED_TRANSLATION_FLAG = 1'b1,
  parameter bit HAS_LONG_FMT = 1'b1,
  parameter bit GRAN_SMALL = 1'b1,
  parameter bit GRAN_MEDIUM = 1'b0,
  parameter bit HAS_WA = 1'b1,
  parameter bit HAS_RA = 1'b1,
  parameter bit HAS_SH = 1'b1,
  parameter bit HAS_BSU = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Translation enable and fault report
  input wire logic transEnable,
  input wire sfc_pkg::sfc_fault_s faultIn,
  // Attributes
  input wire sfc_pkg::sfc_attr_s attrIn,
  input wire sfc_pkg::sfc_attr_s prevAttr,
  output sfc_pkg::sfc_attr_s attrOut,
  // Barriers
  input wire logic barrierValid,
  input wire logic [1:0] barrierDomain,
  output logic [1:0] barrierDomainOut,
  // Walk protection check
  input wire logic s1WalkAccess,
  input wire logic s2DeviceMem,
  output logic walkPermFault,
  // Maintenance
  input wire sfc_pkg::sfc_maint_s maintIn,
  output logic maintBroadcast,
  // Interrupt
  output logic irq
);
  import sfc_pkg::*;

  // Low bound of the captured field by granule support
  localparam int LOW_N = (!HAS_LONG_FMT || GRAN_SMALL) ? SFC_N_SMALL :
                         (GRAN_MEDIUM ? SFC_N_MEDIUM : SFC_N_LARGE); // [RULE_05]

  // Mask keeping bits ADDR_BITS-1 down to LOW_N
  function automatic logic [63:0] fieldMask();
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < 64; i++) begin
      if (i >= LOW_N && i < ADDR_BITS) begin
        m[i] = 1'b1; // [RULE_06]
      end
    end
    return m;
  endfunction : fieldMask

  localparam logic [63:0] FMASK = fieldMask();

  // Writable control bits; reserved positions stay zero
  function automatic logic [31:0] ctrlMask();
    logic [31:0] m;
    m = '0;
    if (HAS_WA) m[SFC_WA_LSB +: 2] = 2'h3;
    if (HAS_RA) m[SFC_RA_LSB +: 2] = 2'h3;
    if (HAS_SH) m[SFC_SH_LSB +: 2] = 2'h3;
    m[SFC_FB_BIT] = 1'b1;
    m[SFC_MA_LSB +: 4] = 4'hf;
    if (HAS_BSU) m[SFC_BSU_LSB +: 2] = 2'h3;
    if (HAS_COMBINED_TRANSLATION_FLAG) m[SFC_PTW_BIT] = 1'b1;
    return m;
  endfunction : ctrlMask

  localparam logic [31:0] CMASK = ctrlMask();

  // Stricter of two shareability codes: outer 01 above inner 10 above non 00/11
  function automatic logic [1:0] shRank(input logic [1:0] s);
    unique case (s)
      2'h1: return 2'h2;
      2'h2: return 2'h1;
      default: return 2'h0;
    endcase
  endfunction : shRank

  function automatic logic [1:0] shMerge(input logic [1:0] a, input logic [1:0] b);
    return (shRank(a) >= shRank(b)) ? a : b;
  endfunction : shMerge

  // Allocation hint: default code keeps the transaction's own hint
  function automatic logic [1:0] allocSel(input logic [1:0] cfg, input logic [1:0] own);
    return (cfg == 2'h0) ? own : cfg; // [RULE_08] [RULE_09]
  endfunction : allocSel

  // Write strobe decode for one register offset
  function automatic logic wrHit(input logic wr, input logic [7:0] addr, input logic [7:0] off);
    return wr && addr == off;
  endfunction : wrHit

  logic [31:0] ctrl_ff;
  logic [63:0] ipa_ff;
  logic [63:0] far_ff;
  logic [2:0] irqStat_ff;
  logic [2:0] irqEn_ff;
  logic capture;
  logic [2:0] events;
  logic protHit;

  // Capture decision on a fault report
  always_comb begin
    capture = 1'b0;
    if (faultIn.valid && HAS_COMBINED_TRANSLATION_FLAG) begin
      unique case (faultIn.kind)
        SFC_FK_TRANSLATION, SFC_FK_ACCESS, SFC_FK_EXTERNAL, SFC_FK_ADDRSIZE: capture = 1'b1; // [RULE_01] [RULE_03]
        SFC_FK_PERMISSION: capture = faultIn.combined_translation_flag && faultIn.s1WalkFault; // [RULE_04]
        default: capture = 1'b0;
      endcase
    end
  end

  assign protHit = ctrl_ff[SFC_PTW_BIT] && s1WalkAccess && s2DeviceMem; // [RULE_15]
  assign events = {maintIn.valid && ctrl_ff[SFC_FB_BIT], protHit, capture};

  // Control register: reserved and unsupported fields masked off
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= SFC_CTRL_RST;
    end else if (wrHit(regWr, regAddr, SFC_OFF_CTRL)) begin
      ctrl_ff <= regWrData & CMASK; // [RULE_16] [RULE_08] [RULE_09] [RULE_10] [RULE_14]
    end
  end

  // Fault address register holds every input address on any fault
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      far_ff <= SFC_ADDR_RST;
    end else if (faultIn.valid) begin
      far_ff <= faultIn.inAddr & FMASK;
    end else if (wrHit(regWr, regAddr, SFC_OFF_FAR_LO)) begin
      far_ff[31:0] <= regWrData & FMASK[31:0];
    end else if (wrHit(regWr, regAddr, SFC_OFF_FAR_HI)) begin
      far_ff[63:32] <= regWrData & FMASK[63:32];
    end
  end

  // Intermediate address register; storage spans the whole field width
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ipa_ff <= SFC_ADDR_RST;
    end else if (capture) begin
      ipa_ff <= faultIn.ipa & FMASK; // [RULE_01] [RULE_07]
    end else if (HAS_COMBINED_TRANSLATION_FLAG && wrHit(regWr, regAddr, SFC_OFF_IPA_LO)) begin
      ipa_ff[31:0] <= regWrData & FMASK[31:0];
    end else if (HAS_COMBINED_TRANSLATION_FLAG && wrHit(regWr, regAddr, SFC_OFF_IPA_HI)) begin
      ipa_ff[63:32] <= regWrData & FMASK[63:32];
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqStat_ff <= SFC_IRQ_RST;
    end else if (wrHit(regWr, regAddr, SFC_OFF_IRQ_CLR)) begin
      irqStat_ff <= (irqStat_ff & ~regWrData[2:0]) | events;
    end else begin
      irqStat_ff <= irqStat_ff | events;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqEn_ff <= SFC_IRQ_RST;
    end else if (wrHit(regWr, regAddr, SFC_OFF_IRQ_EN)) begin
      irqEn_ff <= regWrData[2:0];
    end
  end

  // Interrupt level follows the enabled status held before this edge, one edge late
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_ff & irqEn_ff);
    end
  end

  // Read data, valid in the cycle after the read strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 32'h0;
    end else if (regRd) begin
      unique case (regAddr)
        SFC_OFF_CTRL: regRdData <= ctrl_ff;
        SFC_OFF_IPA_LO: regRdData <= HAS_COMBINED_TRANSLATION_FLAG ? ipa_ff[31:0] : far_ff[31:0]; // [RULE_02]
        SFC_OFF_IPA_HI: regRdData <= HAS_COMBINED_TRANSLATION_FLAG ? ipa_ff[63:32] : far_ff[63:32]; // [RULE_02]
        SFC_OFF_FAR_LO: regRdData <= far_ff[31:0];
        SFC_OFF_FAR_HI: regRdData <= far_ff[63:32];
        SFC_OFF_IRQ_STAT: regRdData <= {29'h0, irqStat_ff};
        SFC_OFF_IRQ_EN: regRdData <= {29'h0, irqEn_ff};
        default: regRdData <= 32'h0;
      endcase
    end else begin
      regRdData <= 32'h0;
    end
  end

  // Attribute overrides when translation disabled (shareability still merged with previous step); else hints pass, share and attribute merge at stage 2
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      attrOut <= '0;
    end else if (!transEnable) begin
      attrOut.wAlloc <= allocSel(ctrl_ff[SFC_WA_LSB +: 2], attrIn.wAlloc); // [RULE_08]
      attrOut.rAlloc <= allocSel(ctrl_ff[SFC_RA_LSB +: 2], attrIn.rAlloc); // [RULE_09]
      attrOut.share <= shMerge(prevAttr.share, ctrl_ff[SFC_SH_LSB +: 2]); // [RULE_10] [RULE_11]
      attrOut.memory_attribute_field <= ctrl_ff[SFC_MA_LSB +: 4]; // [RULE_13]
    end else begin
      attrOut.wAlloc <= attrIn.wAlloc;
      attrOut.rAlloc <= attrIn.rAlloc;
      attrOut.share <= shMerge(prevAttr.share, attrIn.share); // [RULE_11]
      // Simplified combine: stricter (lower) attribute code wins
      attrOut.memory_attribute_field <= (prevAttr.memory_attribute_field < attrIn.memory_attribute_field) ? prevAttr.memory_attribute_field : attrIn.memory_attribute_field; // [RULE_13]
    end
  end

  // Barrier domain raised to at least the configured minimum
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      barrierDomainOut <= 2'h0;
    end else if (barrierValid) begin
      barrierDomainOut <= (ctrl_ff[SFC_BSU_LSB +: 2] > barrierDomain) ? ctrl_ff[SFC_BSU_LSB +: 2] :
                          barrierDomain; // [RULE_14]
    end
  end

  // Walk protection fault and broadcast pulses
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      walkPermFault <= 1'b0;
      maintBroadcast <= 1'b0;
    end else begin
      walkPermFault <= protHit; // [RULE_15]
      maintBroadcast <= maintIn.valid && ctrl_ff[SFC_FB_BIT] &&
                        (maintIn.tlbOp || maintIn.bpInvAll || maintIn.icInvAll); // [RULE_12]
    end
  end

  // Checks
  // The capture step spans the report cycle and the cycle after it
  sequence seqCapt;
    capture ##1 1'b1;
  endsequence

  // Forced broadcast request carrying a maintenance kind that must go out
  sequence seqMaintReq;
    maintIn.valid && ctrl_ff[SFC_FB_BIT] && (maintIn.tlbOp || maintIn.bpInvAll || maintIn.icInvAll);
  endsequence

  // Stage 1 walk touching device memory while protection is on
  sequence seqWalkHit;
    ctrl_ff[SFC_PTW_BIT] && s1WalkAccess && s2DeviceMem;
  endsequence

  // Override where the configured code is stricter than a non-shareable previous step
  sequence seqShOverride;
    !transEnable && (prevAttr.share == 2'h0 || prevAttr.share == 2'h3) &&
      (ctrl_ff[SFC_SH_LSB +: 2] == 2'h1 || ctrl_ff[SFC_SH_LSB +: 2] == 2'h2);
  endsequence

  // Barrier already at or above the configured minimum
  sequence seqBarrierHigh;
    barrierValid && barrierDomain >= ctrl_ff[SFC_BSU_LSB +: 2];
  endsequence

  // Intermediate address capture and its status bit
  AST_CAPTURE: assert property (@(posedge clock) disable iff (!nrst) // [RULE_01]
    seqCapt |-> ipa_ff == ($past(faultIn.ipa) & FMASK)) else $error("ipa not captured");
  AST_CAPT_STATUS: assert property (@(posedge clock) disable iff (!nrst) // [RULE_01]
    capture |=> irqStat_ff[SFC_IRQ_FAULT]) else $error("capture not flagged");

  // Fault address register feeds the alias read when nesting is absent
  AST_FAR_CAPT: assert property (@(posedge clock) disable iff (!nrst) // [RULE_02]
    faultIn.valid |=> far_ff == ($past(faultIn.inAddr) & FMASK)) else $error("fault address not captured");

  // Only the listed fault kinds or an IPA register write move the intermediate address
  AST_NOCAPT_OTHER: assert property (@(posedge clock) disable iff (!nrst) // [RULE_03]
    faultIn.valid && faultIn.kind == SFC_FK_OTHER |-> !capture) else $error("bad capture");
  AST_IPA_HOLD: assert property (@(posedge clock) disable iff (!nrst) // [RULE_03]
    !capture && !(regWr && (regAddr == SFC_OFF_IPA_LO || regAddr == SFC_OFF_IPA_HI)) |=> $stable(ipa_ff))
    else $error("ipa moved without capture");

  // Permission faults count only through a combined_translation_flag stage 1 walk
  AST_PERM: assert property (@(posedge clock) disable iff (!nrst) // [RULE_04]
    faultIn.valid && faultIn.kind == SFC_FK_PERMISSION && !faultIn.s1WalkFault |-> !capture)
    else $error("perm capture");
  AST_PERM_WALK: assert property (@(posedge clock) disable iff (!nrst) // [RULE_04]
    HAS_COMBINED_TRANSLATION_FLAG && faultIn.valid && faultIn.kind == SFC_FK_PERMISSION &&
    faultIn.combined_translation_flag && faultIn.s1WalkFault |-> capture) else $error("walk perm not captured");

  // Nothing stored outside bits M-1 down to N
  AST_HIGH_ZERO: assert property (@(posedge clock) disable iff (!nrst) // [RULE_06]
    (ipa_ff & ~FMASK) == 64'h0) else $error("bits outside field");

  // Allocation and shareability overrides while translation is off
  AST_WALLOC: assert property (@(posedge clock) disable iff (!nrst) // [RULE_08]
    !transEnable && ctrl_ff[SFC_WA_LSB +: 2] != 2'h0 |=> attrOut.wAlloc == $past(ctrl_ff[SFC_WA_LSB +: 2]))
    else $error("write hint not overridden");
  AST_RALLOC: assert property (@(posedge clock) disable iff (!nrst) // [RULE_09]
    !transEnable && ctrl_ff[SFC_RA_LSB +: 2] != 2'h0 |=> attrOut.rAlloc == $past(ctrl_ff[SFC_RA_LSB +: 2]))
    else $error("read hint not overridden");
  AST_SH_OVR: assert property (@(posedge clock) disable iff (!nrst) // [RULE_10]
    seqShOverride |=> attrOut.share == $past(ctrl_ff[SFC_SH_LSB +: 2])) else $error("share not overridden");

  // An outer shareable previous step is never weakened
  AST_SH_OUTER: assert property (@(posedge clock) disable iff (!nrst) // [RULE_11]
    prevAttr.share == 2'h1 |=> attrOut.share == 2'h1) else $error("outer share lost");

  // Forced broadcast follows a request and needs the force bit
  AST_BCAST: assert property (@(posedge clock) disable iff (!nrst) // [RULE_12]
    seqMaintReq |=> maintBroadcast) else $error("broadcast missing");
  AST_FB: assert property (@(posedge clock) disable iff (!nrst) // [RULE_12]
    maintBroadcast |-> $past(ctrl_ff[SFC_FB_BIT])) else $error("broadcast w/o force");

  // Memory attribute override and stage 2 combine
  AST_MA: assert property (@(posedge clock) disable iff (!nrst) // [RULE_13]
    !transEnable |=> attrOut.memory_attribute_field == $past(ctrl_ff[SFC_MA_LSB +: 4])) else $error("memory_attribute_field");
  AST_MA_S2: assert property (@(posedge clock) disable iff (!nrst) // [RULE_13]
    transEnable && prevAttr.memory_attribute_field <= attrIn.memory_attribute_field |=> attrOut.memory_attribute_field == $past(prevAttr.memory_attribute_field))
    else $error("memory_attribute_field combine");

  // Barrier domain never below the minimum, never altered when already above it
  AST_BSU: assert property (@(posedge clock) disable iff (!nrst) // [RULE_14]
    barrierValid |=> barrierDomainOut >= $past(ctrl_ff[SFC_BSU_LSB +: 2])) else $error("barrier low");
  AST_BSU_PASS: assert property (@(posedge clock) disable iff (!nrst) // [RULE_14]
    seqBarrierHigh |=> barrierDomainOut == $past(barrierDomain)) else $error("barrier altered");

  // Walk protection fault only while the protect bit is set; hits are flagged
  AST_PTW: assert property (@(posedge clock) disable iff (!nrst) // [RULE_15]
    seqWalkHit |=> walkPermFault) else $error("no walk fault");
  AST_NO_PTW: assert property (@(posedge clock) disable iff (!nrst) // [RULE_15]
    !ctrl_ff[SFC_PTW_BIT] |=> !walkPermFault) else $error("walk fault without protect");
  AST_PROT_STATUS: assert property (@(posedge clock) disable iff (!nrst) // [RULE_15]
    seqWalkHit |=> irqStat_ff[SFC_IRQ_WALKPROT]) else $error("walk fault not flagged");

  // Reserved control positions stay clear
  AST_RESV: assert property (@(posedge clock) disable iff (!nrst) // [RULE_16]
    ctrl_ff[20] == 1'b0 && ctrl_ff[12:9] == 4'h0) else $error("reserved set");

  // Interrupt level tracks enabled status one edge later
  AST_IRQ_HIGH: assert property (@(posedge clock) disable iff (!nrst)
    (irqStat_ff & irqEn_ff) != 3'h0 |=> irq) else $error("irq missing");
  AST_IRQ_LOW: assert property (@(posedge clock) disable iff (!nrst)
    (irqStat_ff & irqEn_ff) == 3'h0 |=> !irq) else $error("irq spurious");

  // Read data bus idles at zero outside the answer cycle
  AST_RD_IDLE: assert property (@(posedge clock) disable iff (!nrst)
    !regRd |=> regRdData == 32'h0) else $error("read data not idle");

endmodule : sfc_context_ctrl

// *** sfc_context_ctrl_tb.sv ***
// Self-checking bench for the stage 2 context fault-record and control block.
// Assumes the medium granule only (low bound 14) and a 48-bit address field.
`timescale 1ns/100ps

module sfc_context_ctrl_tb;
  import sfc_pkg::*;
  logic clock, nrst, regWr, regRd, rdSeen;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData;
  logic transEnable, barrierValid, s1WalkAccess, s2DeviceMem, walkPermFault, maintBroadcast, irq;
  logic [1:0] barrierDomain, barrierDomainOut;
  sfc_fault_s faultIn;
  sfc_attr_s attrIn, prevAttr, attrOut;
  sfc_maint_s maintIn;
  logic [31:0] expQ[$];
  logic [63:0] ipa, lastIpa;
  int fails, check_count, k;

  // Medium granule chosen so the low bound is not the trivial 12
  sfc_context_ctrl #(.GRAN_SMALL(1'b0), .GRAN_MEDIUM(1'b1)) DUT (.clock(clock), .nrst(nrst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .transEnable(transEnable), .faultIn(faultIn), .attrIn(attrIn), .prevAttr(prevAttr), .attrOut(attrOut),
    .barrierValid(barrierValid), .barrierDomain(barrierDomain), .barrierDomainOut(barrierDomainOut),
    .s1WalkAccess(s1WalkAccess), .s2DeviceMem(s2DeviceMem), .walkPermFault(walkPermFault),
    .maintIn(maintIn), .maintBroadcast(maintBroadcast), .irq(irq));

  sfc_client_model cm (.clock(clock), .transEnable(transEnable), .faultIn(faultIn), .attrIn(attrIn),
    .prevAttr(prevAttr), .barrierValid(barrierValid), .barrierDomain(barrierDomain),
    .s1WalkAccess(s1WalkAccess), .s2DeviceMem(s2DeviceMem), .maintIn(maintIn));

  // Clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr

  // Expected data is queued here and compared by the read monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
  endtask : rd

  // Field kept is bits 47..14; everything else reads as zero
  task automatic expect_ipa(input logic [63:0] v);
    rd(SFC_OFF_IPA_LO, v[31:0] & 32'hffff_c000);
    rd(SFC_OFF_IPA_HI, v[63:32] & 32'h0000_ffff);
  endtask : expect_ipa

  // Read data stands only in the cycle after the strobe
  always @(posedge clock) begin
    if (rdSeen) begin
      chk({32'h0, regRdData}, {32'h0, expQ.pop_front()});
    end
    rdSeen <= regRd;
  end

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // Watchdog, well beyond the hundred or so cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    final_report();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    rdSeen = 1'b0;
    fails = 0;
    check_count = 0;
    void'($urandom(82));
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    rd(SFC_OFF_CTRL, SFC_CTRL_RST);
    wr(SFC_OFF_CTRL, 32'hffff_ffff);
    rd(SFC_OFF_CTRL, 32'h0fef_e000);
    rd(8'h20, 32'h0);
    // The four unconditionally capturing kinds, each with a fresh random address
    for (k = 0; k < 4; k++) begin
      ipa = {$urandom, $urandom};
      cm.send_fault(sfc_fkind_e'(k), 1'b1, 1'b0, ipa);
      expect_ipa(ipa);
    end
    lastIpa = ipa;
    cm.send_fault(SFC_FK_OTHER, 1'b1, 1'b0, ~ipa);
    cm.send_fault(SFC_FK_PERMISSION, 1'b1, 1'b0, ~ipa);
    expect_ipa(lastIpa);
    ipa = {$urandom, $urandom};
    cm.send_fault(SFC_FK_PERMISSION, 1'b1, 1'b1, ipa);
    expect_ipa(ipa);
    // Interrupt masked, enabled, then cleared
    rd(SFC_OFF_IRQ_STAT, 32'h1);
    #1 chk(irq, 1'b0);
    wr(SFC_OFF_IRQ_EN, 32'h1);
    repeat (2) @(posedge clock);
    #1 chk(irq, 1'b1);
    wr(SFC_OFF_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clock);
    #1 chk(irq, 1'b0);
    rd(SFC_OFF_IRQ_STAT, 32'h0);
    // Allocation overrides only while translation is off
    wr(SFC_OFF_CTRL, 32'h0b20_6000);
    cm.set_attr(1'b0, 2'b11, 2'b10);
    repeat (2) @(posedge clock);
    #1 chk({attrOut.wAlloc, attrOut.rAlloc}, 4'b1011);
    cm.set_attr(1'b1, 2'b11, 2'b10);
    repeat (2) @(posedge clock);
    #1 chk({attrOut.wAlloc, attrOut.rAlloc}, 4'b1110);
    // Shareability and memory attribute merged with the previous step, then under override
    cm.set_share(2'b10, 2'b01, 4'h9, 4'h5);
    repeat (2) @(posedge clock);
    #1 chk({attrOut.share, attrOut.memory_attribute_field}, 6'b01_0101);
    wr(SFC_OFF_CTRL, 32'h0baa_6000);
    cm.set_share(2'b01, 2'b11, 4'h9, 4'h5);
    cm.set_attr(1'b0, 2'b11, 2'b10);
    repeat (2) @(posedge clock);
    #1 chk({attrOut.share, attrOut.memory_attribute_field}, 6'b10_1010);
    rd(SFC_OFF_CTRL, 32'h0baa_6000);
    // Barrier domain raised to at least inner, never lowered
    cm.pulse_barrier(2'h0);
    #1 chk(barrierDomainOut, 2'h1);
    cm.pulse_barrier(2'h2);
    #1 chk(barrierDomainOut, 2'h2);
    // Protected walk to device memory
    cm.set_walk(1'b1, 1'b1);
    repeat (2) @(posedge clock);
    #1 chk(walkPermFault, 1'b1);
    cm.set_walk(1'b1, 1'b0);
    repeat (2) @(posedge clock);
    #1 chk(walkPermFault, 1'b0);
    // Forced broadcast is a one-cycle pulse
    cm.pulse_maint();
    #1 chk(maintBroadcast, 1'b1);
    @(posedge clock);
    #1 chk(maintBroadcast, 1'b0);
    rd(SFC_OFF_IRQ_STAT, 32'h6);
    repeat (3) @(posedge clock);
    final_report();
  end
endmodule : sfc_context_ctrl_tb

// *** sfc_pkg.sv ***
// Package for the stage 2 context fault-record and control block.
// Assumes one clock domain and a simple strobe-based register port.
package sfc_pkg;

  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] SFC_OFF_CTRL = 8'h00;
  localparam logic [7:0] SFC_OFF_IPA_LO = 8'h04;
  localparam logic [7:0] SFC_OFF_IPA_HI = 8'h08;
  localparam logic [7:0] SFC_OFF_FAR_LO = 8'h0c;
  localparam logic [7:0] SFC_OFF_FAR_HI = 8'h10;
  localparam logic [7:0] SFC_OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] SFC_OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] SFC_OFF_IRQ_EN = 8'h1c;

  // Control register field positions
  localparam int SFC_WA_LSB = 26;
  localparam int SFC_RA_LSB = 24;
  localparam int SFC_SH_LSB = 22;
  localparam int SFC_FB_BIT = 21;
  localparam int SFC_MA_LSB = 16;
  localparam int SFC_BSU_LSB = 14;
  localparam int SFC_PTW_BIT = 13;

  // Reset values
  localparam logic [31:0] SFC_CTRL_RST = 32'h0000_0000;
  localparam logic [63:0] SFC_ADDR_RST = 64'h0;
  localparam logic [2:0] SFC_IRQ_RST = 3'h0;

  // Granule-dependent low bound of the fault address field
  localparam int SFC_N_SMALL = 12;
  localparam int SFC_N_MEDIUM = 14;
  localparam int SFC_N_LARGE = 16;

  // Interrupt status bit positions
  localparam int SFC_IRQ_FAULT = 0;
  localparam int SFC_IRQ_WALKPROT = 1;
  localparam int SFC_IRQ_BCAST = 2;

  // Fault kinds reported by the walk logic
  typedef enum logic [2:0] {
    SFC_FK_TRANSLATION,
    SFC_FK_ACCESS,
    SFC_FK_EXTERNAL,
    SFC_FK_ADDRSIZE,
    SFC_FK_PERMISSION,
    SFC_FK_OTHER
  } sfc_fkind_e;

  // Fault report from the translation walk
  typedef struct packed {
    logic valid;
    sfc_fkind_e kind;
    logic combined_translation_flag;
    logic s1WalkFault;
    logic [63:0] inAddr;
    logic [63:0] ipa;
  } sfc_fault_s;

  // Maintenance request issued through this context
  typedef struct packed {
    logic valid;
    logic tlbOp;
    logic bpInvAll;
    logic icInvAll;
  } sfc_maint_s;

  // Attributes on a transaction
  typedef struct packed {
    logic [1:0] wAlloc;
    logic [1:0] rAlloc;
    logic [1:0] share;
    logic [3:0] memory_attribute_field;
  } sfc_attr_s;

endpackage : sfc_pkg
